/* File: mbsl_link.v */
// modbus serial slave link: registers, receiver, framing, reply gate
// assumes an axi4-lite master and rxd synchronous to aclk
// Behaviour
// - bit rate from 3-bit code, default 9600
// - character format code, default 8N2
// - station address 1..249, 0 broadcasts
// - reply delay 0..20 ms, default 2 ms
// - reply waits for processing and delay
// - zero timeout disables supervision
// - gap beyond timeout raises link fault
// - variant 0 adds one byte to reads
// - current readout in 0.01 A or 0.1 A
// - fault word reports rejection cause code
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`include "mbsl_defines.vh"
module mbsl_link #(
    parameter MS_CYCLES = `MBSL_MS_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire rxd,
    output wire txd,
    output wire tx_enable,
    input wire [15:0] current_raw,
    output reg irq,
    output reg link_timeout_fault
);
    localparam R_IDLE = 3'd0;
    localparam R_START = 3'd1;
    localparam R_DATA = 3'd2;
    localparam R_PAR = 3'd3;
    localparam R_STOP = 3'd4;
    localparam BIT_HZ = MS_CYCLES * (`MBSL_CLK_HZ / `MBSL_MS_CYCLES);

    function [31:0] bit_cycles_of;
        input [2:0] code;
        begin
            case (code)
                3'd0: bit_cycles_of = BIT_HZ / `MBSL_BPS0;
                3'd1: bit_cycles_of = BIT_HZ / `MBSL_BPS1;
                3'd2: bit_cycles_of = BIT_HZ / `MBSL_BPS2;
                3'd3: bit_cycles_of = BIT_HZ / `MBSL_BPS3;
                3'd4: bit_cycles_of = BIT_HZ / `MBSL_BPS4;
                3'd5: bit_cycles_of = BIT_HZ / `MBSL_BPS5;
                3'd6: bit_cycles_of = BIT_HZ / `MBSL_BPS6;
                default: bit_cycles_of = BIT_HZ / `MBSL_BPS7;
            endcase
        end
    endfunction

    function [15:0] crc_upd;
        input [15:0] c;
        input [7:0] b;
        integer i;
        reg [15:0] x;
        begin
            x = c ^ {8'h00, b};
            for (i = 0; i < 8; i = i + 1) begin
                x = x[0] ? ((x >> 1) ^ `MBSL_CRC_POLY) : (x >> 1);
            end
            crc_upd = x;
        end
    endfunction

    function [15:0] wmerge;
        input [15:0] old;
        input [31:0] d;
        input [3:0] s;
        begin
            wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
        end
    endfunction

    reg [15:0] proto, rate, fmt, stn, dly, tmo, vrnt, scl, fault;
    reg [4:0] sts, msk;
    reg aw_ok, w_ok;
    reg [7:0] aw_a;
    reg [31:0] w_d;
    reg [3:0] w_s;
    reg [31:0] rd_val;
    reg rd_hit;
    reg [31:0] bitc;
    reg [2:0] rst_q;
    reg [31:0] rcnt;
    reg [2:0] rbit;
    reg [7:0] rsh;
    reg rperr;
    reg [7:0] rx_byte;
    reg rx_full, ev_rxb, ev_fr, ev_crc, ev_tmo, ev_done;
    reg fr_act;
    reg [7:0] fr_cnt, fr_addr, fr_fn;
    reg [15:0] fr_crc;
    reg [31:0] gap_cnt;
    reg rep_pend, rep_open, extra_due, hold_v, hold_last, tx_start;
    reg [7:0] hold_d, tx_data;
    reg [31:0] dly_cnt, ms_pre;
    reg [15:0] tmo_ms;
    wire tx_busy;

    wire do_wr = aw_ok && w_ok && !s_axi_bvalid;
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire rx_pop = rd_take && (s_axi_araddr == `MBSL_OFF_RXD);
    wire tx_wr = do_wr && (aw_a == `MBSL_OFF_TXD);
    wire par_en = (fmt[1:0] == 2'd1) || (fmt[1:0] == 2'd2);
    wire [37:0] gap_full = bitc * `MBSL_GAP_BITS;
    wire [31:0] gap_lim = gap_full[31:0];
    wire [15:0] dly_ms = (dly > `MBSL_DELAY_MAX_MS) ? `MBSL_DELAY_MAX_MS : dly;
    wire [47:0] dly_full = dly_ms * MS_CYCLES;
    wire [31:0] dly_cyc = dly_full[31:0];
    wire [15:0] tmo_u = (tmo > `MBSL_TMO_MAX) ? `MBSL_TMO_MAX : tmo;
    wire [22:0] tmo_full = tmo_u * `MBSL_TMO_MS_PER_UNIT;
    wire [15:0] tmo_lim = tmo_full[15:0];
    wire ms_tick = (ms_pre == MS_CYCLES - 1);
    wire [15:0] cur_div = current_raw / 16'h000A;
    wire addr_ok = (fr_addr == `MBSL_BCAST_ADDR) || (stn[15:8] == 8'h00 && fr_addr == stn[7:0]);
    wire frame_end = fr_act && rst_q == R_IDLE && gap_cnt >= gap_lim;
    wire [4:0] ev = {ev_done, ev_tmo, ev_crc, ev_fr, ev_rxb};

    // register read decode
    always @* begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `MBSL_OFF_PROTO: rd_val[15:0] = proto;
            `MBSL_OFF_RATE: rd_val[15:0] = rate;
            `MBSL_OFF_FMT: rd_val[15:0] = fmt;
            `MBSL_OFF_STN: rd_val[15:0] = stn;
            `MBSL_OFF_DLY: rd_val[15:0] = dly;
            `MBSL_OFF_TMO: rd_val[15:0] = tmo;
            `MBSL_OFF_VAR: rd_val[15:0] = vrnt;
            `MBSL_OFF_SCL: rd_val[15:0] = scl;
            `MBSL_OFF_STS: rd_val[4:0] = sts;
            `MBSL_OFF_MSK: rd_val[4:0] = msk;
            `MBSL_OFF_RXD: rd_val[8:0] = {rx_full, rx_byte};
            `MBSL_OFF_TXD: rd_val[0] = hold_v;
            `MBSL_OFF_FAULT: rd_val[15:0] = fault;
            `MBSL_OFF_CUR: rd_val[15:0] = scl[0] ? cur_div : current_raw;
            `MBSL_OFF_STATE: rd_val[15:0] = {fr_fn, 3'b000, extra_due, tx_busy, rep_open, rep_pend, fr_act};
            default: rd_hit = 1'b0;
        endcase
    end

    // axi4-lite slave and register file
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MBSL_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `MBSL_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            aw_ok <= 1'b0;
            w_ok <= 1'b0;
            aw_a <= 8'h00;
            w_d <= 32'h0000_0000;
            w_s <= 4'h0;
            proto <= `MBSL_RST_PROTO;
            rate <= `MBSL_RST_RATE;
            fmt <= `MBSL_RST_FMT;
            stn <= `MBSL_RST_STN;
            dly <= `MBSL_RST_DLY;
            tmo <= `MBSL_RST_TMO;
            vrnt <= `MBSL_RST_VAR;
            scl <= `MBSL_RST_SCL;
            fault <= 16'h0000;
            sts <= 5'h00;
            msk <= 5'h00;
            irq <= 1'b0;
            link_timeout_fault <= 1'b0;
        end else begin
            if (!s_axi_awready && !aw_ok)
                s_axi_awready <= 1'b1;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok <= 1'b1;
                aw_a <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (!s_axi_wready && !w_ok)
                s_axi_wready <= 1'b1;
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok <= 1'b1;
                w_d <= s_axi_wdata;
                w_s <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (do_wr) begin
                aw_ok <= 1'b0;
                w_ok <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `MBSL_RESP_OKAY;
                case (aw_a)
                    `MBSL_OFF_PROTO: proto <= wmerge(proto, w_d, w_s);
                    `MBSL_OFF_RATE: rate <= wmerge(rate, w_d, w_s);
                    `MBSL_OFF_FMT: fmt <= wmerge(fmt, w_d, w_s);
                    `MBSL_OFF_STN: stn <= wmerge(stn, w_d, w_s);
                    `MBSL_OFF_DLY: dly <= wmerge(dly, w_d, w_s);
                    `MBSL_OFF_TMO: tmo <= wmerge(tmo, w_d, w_s);
                    `MBSL_OFF_VAR: vrnt <= wmerge(vrnt, w_d, w_s);
                    `MBSL_OFF_SCL: scl <= wmerge(scl, w_d, w_s);
                    `MBSL_OFF_MSK: if (w_s[0]) msk <= w_d[4:0];
                    `MBSL_OFF_STS, `MBSL_OFF_TXD, `MBSL_OFF_RXD: ;
                    `MBSL_OFF_FAULT: ;
                    default: s_axi_bresp <= `MBSL_RESP_SLVERR;
                endcase
            end
            // crc event beats a software write
            if (ev_crc)
                fault <= `MBSL_FAULT_CRC;
            else if (do_wr && aw_a == `MBSL_OFF_FAULT)
                fault <= wmerge(fault, w_d, w_s);
            // sticky status, write one to clear, new event wins
            if (do_wr && aw_a == `MBSL_OFF_STS && w_s[0])
                sts <= (sts & ~w_d[4:0]) | ev;
            else
                sts <= sts | ev;
            irq <= |(sts & msk);
            link_timeout_fault <= sts[`MBSL_ST_TMO];
            if (!s_axi_arready && !s_axi_rvalid)
                s_axi_arready <= 1'b1;
            if (rd_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_hit ? `MBSL_RESP_OKAY : `MBSL_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // character receiver, bit time from rate code
    always @(posedge aclk) begin
        if (!aresetn) begin
            bitc <= bit_cycles_of(3'd5);
            rst_q <= R_IDLE;
            rcnt <= 32'h0000_0000;
            rbit <= 3'd0;
            rsh <= 8'h00;
            rperr <= 1'b0;
            rx_byte <= 8'h00;
            rx_full <= 1'b0;
            ev_rxb <= 1'b0;
        end else begin
            bitc <= bit_cycles_of(rate[2:0]);
            ev_rxb <= 1'b0;
            if (rx_pop)
                rx_full <= 1'b0;
            if (rst_q != R_IDLE && rcnt != 32'h0000_0000) begin
                rcnt <= rcnt - 32'h0000_0001;
            end else begin
                case (rst_q)
                    R_IDLE: if (!rxd) begin
                        rcnt <= {1'b0, bitc[31:1]};
                        rst_q <= R_START;
                    end
                    R_START: begin
                        rcnt <= bitc - 32'h0000_0001;
                        rbit <= 3'd0;
                        rperr <= 1'b0;
                        rst_q <= rxd ? R_IDLE : R_DATA;
                    end
                    R_DATA: begin
                        rsh <= {rxd, rsh[7:1]};
                        rbit <= rbit + 3'd1;
                        rcnt <= bitc - 32'h0000_0001;
                        if (rbit == 3'd7)
                            rst_q <= par_en ? R_PAR : R_STOP;
                    end
                    R_PAR: begin
                        rperr <= (^rsh ^ rxd) != (fmt[1:0] == 2'd2);
                        rcnt <= bitc - 32'h0000_0001;
                        rst_q <= R_STOP;
                    end
                    R_STOP: begin
                        rst_q <= R_IDLE;
                        if (rxd && !rperr) begin
                            rx_byte <= rsh;
                            rx_full <= 1'b1;
                            ev_rxb <= 1'b1;
                        end
                    end
                    default: rst_q <= R_IDLE;
                endcase
            end
        end
    end

    // frame assembly, silence detection, crc and address check
    always @(posedge aclk) begin
        if (!aresetn) begin
            fr_act <= 1'b0;
            fr_cnt <= 8'h00;
            fr_addr <= 8'h00;
            fr_fn <= 8'h00;
            fr_crc <= `MBSL_CRC_INIT;
            gap_cnt <= 32'h0000_0000;
            ev_fr <= 1'b0;
            ev_crc <= 1'b0;
        end else begin
            ev_fr <= 1'b0;
            ev_crc <= 1'b0;
            if (rst_q != R_IDLE || ev_rxb)
                gap_cnt <= 32'h0000_0000;
            else if (fr_act)
                gap_cnt <= gap_cnt + 32'h0000_0001;
            if (ev_rxb) begin
                fr_act <= 1'b1;
                if (!fr_act) begin
                    fr_cnt <= 8'h01;
                    fr_addr <= rx_byte;
                    fr_crc <= crc_upd(`MBSL_CRC_INIT, rx_byte);
                end else begin
                    if (fr_cnt != 8'hFF)
                        fr_cnt <= fr_cnt + 8'h01;
                    if (fr_cnt == 8'h01)
                        fr_fn <= rx_byte;
                    fr_crc <= crc_upd(fr_crc, rx_byte);
                end
            end else if (frame_end) begin
                fr_act <= 1'b0;
                if (proto == 16'h0000 && fr_cnt >= 8'h04 && addr_ok) begin
                    ev_fr <= (fr_crc == 16'h0000);
                    ev_crc <= (fr_crc != 16'h0000);
                end
            end
        end
    end

    // reply gate: waits for delay and first byte
    always @(posedge aclk) begin
        if (!aresetn) begin
            rep_pend <= 1'b0;
            rep_open <= 1'b0;
            extra_due <= 1'b0;
            dly_cnt <= 32'h0000_0000;
            hold_v <= 1'b0;
            hold_last <= 1'b0;
            hold_d <= 8'h00;
            tx_start <= 1'b0;
            tx_data <= 8'h00;
            ev_done <= 1'b0;
        end else begin
            tx_start <= 1'b0;
            ev_done <= 1'b0;
            if (ev_fr) begin
                rep_pend <= (fr_addr != `MBSL_BCAST_ADDR);
                rep_open <= 1'b0;
                hold_v <= 1'b0;
                dly_cnt <= 32'h0000_0000;
                extra_due <= !vrnt[0] && (fr_fn == `MBSL_FN_READ_HOLD || fr_fn == `MBSL_FN_READ_INPUT);
            end else begin
                if (rep_pend && !rep_open) begin
                    if (dly_cnt >= dly_cyc)
                        rep_open <= 1'b1;
                    else
                        dly_cnt <= dly_cnt + 32'h0000_0001;
                end
                if (tx_wr && rep_pend && !hold_v && w_s[0]) begin
                    hold_v <= 1'b1;
                    hold_d <= w_d[7:0];
                    hold_last <= w_d[8];
                end
                if (rep_open && hold_v && !tx_busy && !tx_start) begin
                    tx_start <= 1'b1;
                    tx_data <= hold_d;
                    if (hold_last && extra_due) begin
                        hold_d <= 8'h00;
                        extra_due <= 1'b0;
                    end else begin
                        hold_v <= 1'b0;
                        if (hold_last) begin
                            rep_pend <= 1'b0;
                            rep_open <= 1'b0;
                            ev_done <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // inactivity supervision in milliseconds
    always @(posedge aclk) begin
        if (!aresetn) begin
            ms_pre <= 32'h0000_0000;
            tmo_ms <= 16'h0000;
            ev_tmo <= 1'b0;
        end else begin
            ev_tmo <= 1'b0;
            ms_pre <= ms_tick ? 32'h0000_0000 : ms_pre + 32'h0000_0001;
            if (ev_fr || tmo_lim == 16'h0000) begin
                tmo_ms <= 16'h0000;
            end else if (ms_tick && tmo_ms != 16'hFFFF) begin
                tmo_ms <= tmo_ms + 16'h0001;
                if (tmo_ms == tmo_lim)
                    ev_tmo <= 1'b1;
            end
        end
    end

    mbsl_tx u_tx (
        .aclk(aclk),
        .aresetn(aresetn),
        .bit_cycles(bitc),
        .fmt(fmt[1:0]),
        .start(tx_start),
        .data(tx_data),
        .txd(txd),
        .de(tx_enable),
        .busy(tx_busy)
    );
endmodule // mbsl_link

/* File: mbsl_defines.vh */
// constants for the modbus slave link block
// assumes a 100 MHz system clock and an axi4-lite register bus
`ifndef MBSL_DEFINES_VH
`define MBSL_DEFINES_VH
`define MBSL_CLK_HZ 100000000
`define MBSL_MS_CYCLES (`MBSL_CLK_HZ / 1000)
`define MBSL_BPS0 300
`define MBSL_BPS1 600
`define MBSL_BPS2 1200
`define MBSL_BPS3 2400
`define MBSL_BPS4 4800
`define MBSL_BPS5 9600
`define MBSL_BPS6 19200
`define MBSL_BPS7 38400
`define MBSL_GAP_BITS 6'd39
`define MBSL_DELAY_MAX_MS 16'h0014
`define MBSL_TMO_MAX 16'h0258
`define MBSL_TMO_MS_PER_UNIT 7'd100
`define MBSL_OFF_PROTO 8'h00
`define MBSL_OFF_RATE 8'h04
`define MBSL_OFF_FMT 8'h08
`define MBSL_OFF_STN 8'h0C
`define MBSL_OFF_DLY 8'h10
`define MBSL_OFF_TMO 8'h14
`define MBSL_OFF_VAR 8'h18
`define MBSL_OFF_SCL 8'h1C
`define MBSL_OFF_STS 8'h20
`define MBSL_OFF_MSK 8'h24
`define MBSL_OFF_RXD 8'h28
`define MBSL_OFF_TXD 8'h2C
`define MBSL_OFF_FAULT 8'h30
`define MBSL_OFF_CUR 8'h34
`define MBSL_OFF_STATE 8'h38
`define MBSL_RST_PROTO 16'h0000
`define MBSL_RST_RATE 16'h0005
`define MBSL_RST_FMT 16'h0000
`define MBSL_RST_STN 16'h0001
`define MBSL_RST_DLY 16'h0002
`define MBSL_RST_TMO 16'h0000
`define MBSL_RST_VAR 16'h0001
`define MBSL_RST_SCL 16'h0000
`define MBSL_ST_RXB 0
`define MBSL_ST_FRAME 1
`define MBSL_ST_CRC 2
`define MBSL_ST_TMO 3
`define MBSL_ST_DONE 4
`define MBSL_FAULT_WORD_ADDR 16'h8001
`define MBSL_FAULT_CRC 16'h0003
`define MBSL_BCAST_ADDR 8'h00
`define MBSL_FN_READ_HOLD 8'h03
`define MBSL_FN_READ_INPUT 8'h04
`define MBSL_CRC_INIT 16'hFFFF
`define MBSL_CRC_POLY 16'hA001
`define MBSL_RESP_OKAY 2'b00
`define MBSL_RESP_SLVERR 2'b10
`endif

/* File: mbsl_tx.v */
// serial transmitter: start, 8 data, parity for format codes 1 and 2, stop bits
// assumes start is a pulse given only while busy is low
`include "mbsl_defines.vh"
module mbsl_tx (
    input wire aclk,
    input wire aresetn,
    input wire [31:0] bit_cycles,
    input wire [1:0] fmt,
    input wire start,
    input wire [7:0] data,
    output reg txd,
    output reg de,
    output reg busy
);
    reg [11:0] sh;
    reg [3:0] nb;
    reg [31:0] cnt;
    reg [11:0] frame;
    reg [3:0] nbits;

    // character framing per format code
    always @* begin
        case (fmt)
            2'd0: begin
                frame = {2'b11, 1'b1, data, 1'b0};
                nbits = 4'd11;
            end
            2'd1: begin
                frame = {2'b11, ^data, data, 1'b0};
                nbits = 4'd11;
            end
            2'd2: begin
                frame = {2'b11, ~^data, data, 1'b0};
                nbits = 4'd11;
            end
            default: begin
                frame = {3'b111, data, 1'b0};
                nbits = 4'd10;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            sh <= 12'h000;
            nb <= 4'h0;
            cnt <= 32'h0000_0000;
            txd <= 1'b1;
            de <= 1'b0;
            busy <= 1'b0;
        end else if (!busy) begin
            if (start) begin
                sh <= frame;
                nb <= nbits;
                cnt <= bit_cycles - 32'h0000_0001;
                txd <= 1'b0;
                de <= 1'b1;
                busy <= 1'b1;
            end
        end else if (cnt != 32'h0000_0000) begin
            cnt <= cnt - 32'h0000_0001;
        end else if (nb == 4'h1) begin
            busy <= 1'b0;
            de <= 1'b0;
            txd <= 1'b1;
        end else begin
            sh <= {1'b1, sh[11:1]};
            txd <= sh[1];
            nb <= nb - 4'h1;
            cnt <= bit_cycles - 32'h0000_0001;
        end
    end
endmodule // mbsl_tx

/* File: mbsl_monitor.sv */
// checker for the modbus slave link ports
// bound to mbsl_link from the testbench top
module mbsl_monitor (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire txd,
    input wire tx_enable,
    input wire link_timeout_fault
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_aw_take; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_take: assert property (p_aw_take) else $error("awready held");
    property p_b_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid; endproperty
    a_b_take: assert property (p_b_take) else $error("no write response");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_take; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_take: assert property (p_r_take) else $error("no read data");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    property p_r_bad; s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h38 |=> s_axi_rresp == 2'b10 && s_axi_rdata == 0;
    endproperty
    a_r_bad: assert property (p_r_bad) else $error("unmapped read ok");
    property p_r_cfg; s_axi_arvalid && s_axi_arready && s_axi_araddr < 8'h20 && s_axi_araddr[1:0] == 2'b00
        |=> s_axi_rresp == 2'b00 && s_axi_rdata[31:16] == 16'h0000; endproperty
    a_r_cfg: assert property (p_r_cfg) else $error("config read wrong");
    property p_idle; !tx_enable |-> txd; endproperty
    a_idle: assert property (p_idle) else $error("line not idle");
    property p_flt_clr; $fell(link_timeout_fault) |-> $past(s_axi_bvalid); endproperty
    a_flt_clr: assert property (p_flt_clr) else $error("fault fell unasked");
endmodule // mbsl_monitor

/* File: mbsl_host.sv */
// host model: sends 8n1 characters on rxd, decodes replies on txd
// assumes rate code 0 and format code 3 set in the link
module mbsl_host #(parameter int BIT = 2604) (
    input wire logic aclk,
    output logic rxd,
    input wire logic txd,
    input wire logic tx_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got = 8'h00;
    int cnt = 0;
    initial rxd = 1'b1;
    // same rate and framing as the link, lsb first, idle high
    task automatic send(input logic [7:0] b);
        logic [9:0] f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge aclk);
        end
    endtask
    always @(negedge txd) begin
        repeat (BIT / 2) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge aclk);
            got[i] = txd;
        end
        cnt++;
    end
endmodule // mbsl_host

/* File: tb.sv */
// testbench top for the modbus slave link
// axi4-lite master tasks and host model, 100 MHz clock
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = 100 * 1000 / 300;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [15:0] current_raw = 16'h04d2;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire awready, wready, bvalid, arready, rvalid, rxd, txd, tx_enable, irq, fault;
    int errors = 0, total_checks = 0, n;
    logic [31:0] d;
    logic [1:0] r;
    mbsl_link #(.MS_CYCLES(100)) u_mbsl_link (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxd(rxd),
        .txd(txd), .tx_enable(tx_enable), .current_raw(current_raw), .irq(irq), .link_timeout_fault(fault));
    mbsl_host #(.BIT(BIT)) u_mbsl_host (.aclk(aclk), .rxd(rxd), .txd(txd), .tx_enable(tx_enable));
    initial forever #5 aclk = ~aclk;
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic to(input logic c);
        if (!c) begin
            chk("wait", 32'h0000_0000, 32'h0000_0001);
            stop_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int k = 0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            bready <= bvalid && !bready;
            rs = bresp;
            k++;
        end while (!(bvalid && bready) && k < 200);
        to(k < 200);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int k = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            rready <= rvalid && !rready;
            v = rdata;
            rs = rresp;
            k++;
        end while (!(rvalid && rready) && k < 200);
        to(k < 200);
    endtask
    function automatic logic [15:0] crc2(input logic [15:0] b);
        logic [15:0] c = 16'hffff;
        for (int i = 0; i < 16; i++) begin
            if (i % 8 == 0)
                c = c ^ {8'h00, b[i +: 8]};
            c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    task automatic t_regs;
        logic [127:0] rv = 128'h0000_0001_0000_0002_0001_0000_0005_0000;
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4), d, r);
            chk("cfg reset", d, {16'h0000, rv[i * 16 +: 16]});
        end
        rd(8'h3c, d, r);
        chk("unmapped rd", {d[29:0], r}, 32'h0000_0002);
        wr(8'h40, 32'h0000_0001, r);
        chk("unmapped wr", 32'(r), 32'h0000_0002);
        $display("regs done");
    endtask
    task automatic t_scale;
        rd(8'h34, d, r);
        chk("current", d, 32'h0000_04d2);
        wr(8'h1c, 32'h0000_0001, r);
        rd(8'h34, d, r);
        chk("current", d, 32'h0000_007b);
        $display("scale done");
    endtask
    task automatic t_frame;
        logic [31:0] f;
        f = {crc2(16'h03f9), 16'h03f9};
        wr(8'h04, 32'h0000_0000, r);
        wr(8'h08, 32'h0000_0003, r);
        wr(8'h0c, 32'h0000_00f9, r);
        for (int i = 0; i < 4; i++) u_mbsl_host.send(f[i * 8 +: 8]);
        d = 32'h0000_0000;
        for (n = 0; n < 60000 && d[1] !== 1'b1; n++) rd(8'h20, d, r);
        chk("frame ok", 32'(d[1]), 32'h0000_0001);
        wr(8'h2c, 32'h0000_01a5, r);
        for (n = 0; n < 500 && !tx_enable; n++) @(posedge aclk);
        chk("reply delay", 32'(n >= 175 && n < 215), 32'h0000_0001);
        for (n = 0; n < 40000 && u_mbsl_host.cnt == 0; n++) @(posedge aclk);
        chk("reply byte", 32'(u_mbsl_host.got), 32'h0000_00a5);
        repeat (4000) @(posedge aclk);
        chk("reply length", 32'(u_mbsl_host.cnt), 32'h0000_0001);
        $display("frame done");
    endtask
    task automatic t_tmo;
        chk("no timeout", 32'(fault), 32'h0000_0000);
        wr(8'h24, 32'h0000_0008, r);
        wr(8'h14, 32'h0000_0001, r);
        for (n = 0; n < 20000 && !fault; n++) @(posedge aclk);
        chk("timeout", 32'(fault && n > 9900), 32'h0000_0001);
        chk("irq on", 32'(irq), 32'h0000_0001);
        wr(8'h24, 32'h0000_0000, r);
        repeat (2) @(posedge aclk);
        chk("irq masked", 32'(irq), 32'h0000_0000);
        wr(8'h20, 32'h0000_0008, r);
        repeat (2) @(posedge aclk);
        chk("fault clear", 32'(fault), 32'h0000_0000);
        $display("timeout done");
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_scale();
        t_frame();
        t_tmo();
        stop_test();
    end
endmodule // tb
bind mbsl_link mbsl_monitor u_mbsl_monitor (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txd, .tx_enable, .link_timeout_fault);
